// [rtl/temp_aging_regs.sv]
// Temperature readout and aging trim registers with conversion sequencing
`timescale 1ns/10ps
module temp_aging_regs
    import temp_aging_pkg::*;
#(
    parameter logic [TIMER_W-1:0] PERIOD_CYCLES = TIMER_W'(MANUAL_CONVERSION_REQUEST_PERIOD_CYCLES)
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Register access from the serial engine
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    output logic [DATA_W-1:0] o_reg_rdata,
    // Conversion control
    input wire logic i_manual_conversion_request,
    input wire logic i_on_backup,
    output logic o_busy,
    // Temperature sensor
    output logic o_sense_start,
    input wire logic i_sense_done,
    input wire logic [TEMP_W-1:0] i_sense_value,
    // Capacitor array trim
    output logic o_aging_apply,
    output logic [DATA_W-1:0] o_aging_trim,
    // Serial clock pin
    output logic o_scl_out,
    output logic o_scl_oe
);
    interval_if tif ();

    // Backup supply synchroniser
    logic [2:0] backup_sync;
    logic on_backup;

    // Stored register contents and the read multiplexer output
    logic [DATA_W-1:0] aging_trim;
    logic [TEMP_W-1:0] temperature;
    logic [DATA_W-1:0] next_rdata;

    // Conversion sequencing
    manual_conversion_request_state_e state;
    manual_conversion_request_src_e src;
    manual_conversion_request_src_e next_src;
    logic powerup_pending;
    logic request_pending;
    logic access;
    logic start;
    logic restart;
    logic result_valid;
    logic temp_changed;

    manual_conversion_request_interval_timer #(
        .PERIOD_CYCLES(PERIOD_CYCLES)
    ) u_timer (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .tmr(tif.timer)
    );

    // Backup supply pin: change counts when stages two and three agree
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            backup_sync <= 3'h0;
            on_backup <= 1'b0;
        end else begin
            backup_sync <= {backup_sync[1:0], i_on_backup};
            if (backup_sync[1] == backup_sync[2]) begin
                on_backup <= backup_sync[2];
            end
        end
    end

    assign access = i_reg_wr | i_reg_rd;
    assign start = (state == MANUAL_CONVERSION_REQUEST_IDLE) &&
        (powerup_pending || request_pending || tif.due);
    // Timer restarts with each start, so a due never lands mid-conversion
    assign restart = start;
    assign tif.restart = restart;

    // A result is taken only while a conversion runs
    assign result_valid = (state == MANUAL_CONVERSION_REQUEST_RUN) && i_sense_done;
    assign temp_changed = (i_sense_value != temperature);

    // Pending requests; a new request in the start cycle is kept
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            powerup_pending <= 1'b1; // [RULE3]
        end else if (start && powerup_pending) begin
            powerup_pending <= access && on_backup;
        end else if (access && on_backup) begin
            powerup_pending <= 1'b1; // [RULE4]
        end
    end

    // Set wins over clear, so a request in the start cycle is not lost
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            request_pending <= 1'b0;
        end else if (i_manual_conversion_request) begin
            request_pending <= 1'b1;
        end else if (start && !powerup_pending) begin
            request_pending <= 1'b0;
        end
    end

    // Source priority: power-up or backup access, then manual, then periodic
    always_comb begin
        next_src = SRC_PERIODIC;
        if (powerup_pending) begin
            next_src = SRC_POWERUP;
        end else if (request_pending) begin
            next_src = SRC_MANUAL;
        end
    end

    // Conversion sequencer
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= MANUAL_CONVERSION_REQUEST_IDLE;
            src <= SRC_POWERUP;
            o_sense_start <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_sense_start <= 1'b0;
            case (state)
                MANUAL_CONVERSION_REQUEST_IDLE: begin
                    if (start) begin
                        state <= MANUAL_CONVERSION_REQUEST_RUN;
                        o_sense_start <= 1'b1;
                        o_busy <= 1'b1;
                        src <= next_src;
                    end
                end
                MANUAL_CONVERSION_REQUEST_RUN: begin
                    if (i_sense_done) begin
                        state <= MANUAL_CONVERSION_REQUEST_IDLE;
                        o_busy <= 1'b0;
                    end
                end
                default: begin
                    state <= MANUAL_CONVERSION_REQUEST_IDLE;
                    o_busy <= 1'b0;
                end
            endcase
        end
    end

    // Temperature result; host writes never reach it
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            temperature <= TEMP_ZERO_CODE; // [RULE3]
        end else if (result_valid) begin
            temperature <= i_sense_value; // [RULE1] [RULE5] [RULE6]
        end
    end

    // Aging trim register and its application to the array
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aging_trim <= AGING_TRIM_RESET;
        end else if (i_reg_wr && i_reg_addr == AGING_TRIM_ADDR) begin
            aging_trim <= i_reg_wdata; // [RULE8]
        end
    end

    // Trim code is held between applies so the array sees a stable value
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_aging_apply <= 1'b0;
            o_aging_trim <= AGING_TRIM_RESET;
        end else begin
            o_aging_apply <= 1'b0;
            if (result_valid && (src != SRC_PERIODIC || temp_changed)) begin
                o_aging_apply <= 1'b1; // [RULE9]
                o_aging_trim <= aging_trim; // [RULE8]
            end
        end
    end

    // Read multiplexer; unmapped addresses and undefined bits read as zero
    always_comb begin
        next_rdata = READ_UNMAPPED;
        case (i_reg_addr)
            AGING_TRIM_ADDR: begin
                next_rdata = aging_trim;
            end
            TEMP_INTEGER_ADDR: begin
                next_rdata = temperature[TEMP_INT_MSB:TEMP_INT_LSB]; // [RULE2]
            end
            TEMP_FRACTION_ADDR: begin
                next_rdata = {temperature[TEMP_FRAC_MSB:TEMP_FRAC_LSB],
                    FRAC_PAD_W'(0)}; // [RULE2] [RULE10]
            end
            default: begin
                next_rdata = READ_UNMAPPED;
            end
        endcase
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= READ_UNMAPPED;
        end else if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
        end
    end

    // Serial clock is never driven: enable high means released
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_scl_out <= 1'b1;
            o_scl_oe <= 1'b1;
        end else begin
            o_scl_out <= 1'b1; // [RULE7]
            o_scl_oe <= 1'b1; // [RULE7]
        end
    end
endmodule // temp_aging_regs

// [rtl/temp_aging_pkg.sv]
// Constants and types shared by the temperature and aging trim register block
// What this block does
// (RULE1) Temperature is a ten-bit two's complement value, one step per quarter degree.
// (RULE2) Integer eight bits live at 11h; two fraction bits at 12h bits 7:6.
// (RULE3) Power reset loads zero degrees into both registers and starts a conversion.
// (RULE4) Convert at power-up, on bus access on backup, then every 64 seconds.
// (RULE5) Results refresh after every requested conversion and every periodic conversion.
// (RULE6) Temperature registers are read-only; host writes leave them unchanged.
// (RULE7) The device never holds the serial clock low to stretch cycles.
// (RULE8) Aging trim byte is two's complement: bit 7 sign, bits 6:0 magnitude.
// (RULE9) Trim is applied on periodic conversions with changed temperature and on manual, power-up and backup access conversions.
// (RULE10) Fraction register bits 5:0 always read as zero.
package temp_aging_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned TEMP_W = 10;
    localparam logic [ADDR_W-1:0] AGING_TRIM_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] TEMP_INTEGER_ADDR = 8'h11;
    localparam logic [ADDR_W-1:0] TEMP_FRACTION_ADDR = 8'h12;
    localparam logic [DATA_W-1:0] AGING_TRIM_RESET = 8'h00;
    localparam logic [TEMP_W-1:0] TEMP_ZERO_CODE = 10'h000;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;
    localparam int unsigned TEMP_INT_MSB = 9;
    localparam int unsigned TEMP_INT_LSB = 2;
    localparam int unsigned TEMP_FRAC_MSB = 1;
    localparam int unsigned TEMP_FRAC_LSB = 0;
    localparam int unsigned FRAC_FIELD_W = 2;
    localparam int unsigned FRAC_PAD_W = 6;
    localparam int unsigned AGING_SIGN_BIT = 7;
    localparam int unsigned AGING_MAG_W = 7;
    localparam int unsigned TIMER_W = 32;
    localparam longint unsigned CLK_HZ = 40_000_000;
    localparam longint unsigned MANUAL_CONVERSION_REQUEST_PERIOD_S = 64;
    localparam longint unsigned MANUAL_CONVERSION_REQUEST_PERIOD_CYCLES = MANUAL_CONVERSION_REQUEST_PERIOD_S * CLK_HZ;
    typedef enum logic [1:0] {
        MANUAL_CONVERSION_REQUEST_IDLE,
        MANUAL_CONVERSION_REQUEST_RUN
    } manual_conversion_request_state_e;
    typedef enum logic [1:0] {
        SRC_PERIODIC,
        SRC_MANUAL,
        SRC_POWERUP
    } manual_conversion_request_src_e;
endpackage

// [rtl/interval_if.sv]
// Handshake between the conversion sequencer and its interval timer
`timescale 1ns/10ps
interface interval_if;
    logic restart;
    logic due;
    modport sequencer (output restart, input due);
    modport timer (input restart, output due);
endinterface

// [rtl/manual_conversion_request_interval_timer.sv]
// Periodic conversion interval timer
`timescale 1ns/10ps
module manual_conversion_request_interval_timer
    import temp_aging_pkg::*;
#(
    parameter logic [TIMER_W-1:0] PERIOD_CYCLES = TIMER_W'(MANUAL_CONVERSION_REQUEST_PERIOD_CYCLES)
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Sequencer side
    interval_if.timer tmr
);
    logic [TIMER_W-1:0] count;

    // Counts from the start of the last conversion; due is one pulse
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= '0;
            tmr.due <= 1'b0;
        end else if (tmr.restart) begin
            count <= '0;
            tmr.due <= 1'b0;
        end else if (count == PERIOD_CYCLES - TIMER_W'(1)) begin
            count <= '0;
            tmr.due <= 1'b1; // [RULE4]
        end else begin
            count <= count + TIMER_W'(1);
            tmr.due <= 1'b0;
        end
    end
endmodule // manual_conversion_request_interval_timer

// [tb/temp_aging_regs_properties.sv]
// Port checks for the temperature and aging trim registers
`timescale 1ns/10ps
module temp_aging_props
    import temp_aging_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Register access
    input wire logic i_reg_rd,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [DATA_W-1:0] o_reg_rdata,
    // Conversion and sensor
    input wire logic i_manual_conversion_request,
    input wire logic o_busy,
    input wire logic o_sense_start,
    input wire logic i_sense_done,
    input wire logic [TEMP_W-1:0] i_sense_value,
    // Trim and serial clock
    input wire logic o_aging_apply,
    input wire logic [DATA_W-1:0] o_aging_trim,
    input wire logic o_scl_out,
    input wire logic o_scl_oe
);
    logic [DATA_W-1:0] last_int, last_frac;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_done;
        i_sense_done && o_busy;
    endsequence
    sequence s_rd(a);
        i_reg_rd && i_reg_addr == a;
    endsequence
    // Last delivered result as the host should see it
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last_int <= 8'h00;
            last_frac <= 8'h00;
        end else if (i_sense_done && o_busy) begin
            last_int <= i_sense_value[9:2];
            last_frac <= {i_sense_value[1:0], 6'h00};
        end
    end
    scl_release_a: assert property (o_scl_out && o_scl_oe)
        else $error("serial clock pulled");
    powerup_start_a: assert property ($rose(i_reset_n) |-> ##[0:2] o_sense_start)
        else $error("no power-up conversion");
    start_pulse_a: assert property (o_sense_start |-> o_busy ##1 !o_sense_start)
        else $error("bad start pulse");
    done_end_a: assert property (s_done |=> !o_busy)
        else $error("busy after done");
    manual_start_a: assert property (i_manual_conversion_request && !o_busy
        |-> ##[1:40] o_sense_start)
        else $error("manual request lost");
    trim_cause_a: assert property (o_aging_apply |-> $past(i_sense_done))
        else $error("trim without result");
    int_read_a: assert property (s_rd(TEMP_INTEGER_ADDR) |=> o_reg_rdata == $past(last_int))
        else $error("integer byte wrong");
    frac_read_a: assert property (s_rd(TEMP_FRACTION_ADDR) |=> o_reg_rdata == $past(last_frac))
        else $error("fraction byte wrong");
    trim_hold_a: assert property (!o_aging_apply |-> $stable(o_aging_trim))
        else $error("trim changed without apply");
endmodule // temp_aging_props
bind temp_aging_regs temp_aging_props u_props (.i_core_clk, .i_reset_n, .i_reg_rd, .i_reg_addr,
    .o_reg_rdata, .i_manual_conversion_request, .o_busy, .o_sense_start, .i_sense_done,
    .o_aging_apply, .o_aging_trim, .o_scl_out, .o_scl_oe, .i_sense_value);

// [tb/temp_sensor_model.sv]
// Behavioural temperature sensor answering after a set delay
`timescale 1ns/10ps
module temp_sensor_model
    import temp_aging_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_start,
    input wire logic [3:0] i_delay,
    input wire logic [TEMP_W-1:0] i_value,
    output logic o_done,
    output logic [TEMP_W-1:0] o_value
);
    int cnt = 0;
    initial o_done = 1'b0;
    initial o_value = '0;
    // Value toggles outside the done cycle
    always @(posedge i_core_clk) begin
        o_done <= 1'b0;
        o_value <= ~o_value;
        if (i_start) cnt <= i_delay + 1;
        else if (cnt > 1) cnt <= cnt - 1;
        else if (cnt == 1) begin
            cnt <= 0;
            o_done <= 1'b1;
            o_value <= i_value;
        end
    end
endmodule // temp_sensor_model

// [tb/temp_aging_register_block_tb.sv]
// Self-checking bench for the temperature and aging trim registers
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module temp_aging_register_block_tb;
    import temp_aging_pkg::*;
    logic i_core_clk = 0, i_reset_n = 0, i_reg_wr = 0, i_reg_rd = 0, rd_d = 0;
    logic i_manual_conversion_request = 0, i_on_backup = 0;
    logic [ADDR_W-1:0] i_reg_addr = '0;
    logic [DATA_W-1:0] i_reg_wdata = '0, o_reg_rdata, o_aging_trim, exp_trim = '0, exp_rd;
    logic o_busy, o_sense_start, i_sense_done, o_aging_apply, o_scl_out, o_scl_oe;
    logic [3:0] dly = 4'h8;
    logic [TEMP_W-1:0] tval, i_sense_value;
    logic [DATA_W-1:0] notes[$];
    int checks = 0, miscompares = 0, applies = 0, starts = 0, s0;
    initial forever #12.5 i_core_clk = ~i_core_clk;
    temp_aging_regs #(.PERIOD_CYCLES(200)) DUT (.i_core_clk, .i_reset_n, .i_reg_addr,
        .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_manual_conversion_request,
        .i_on_backup, .o_busy, .o_sense_start, .i_sense_done, .i_sense_value,
        .o_aging_apply, .o_aging_trim, .o_scl_out, .o_scl_oe);
    temp_sensor_model u_sensor (.i_core_clk, .i_start(o_sense_start), .i_delay(dly),
        .i_value(tval), .o_done(i_sense_done), .o_value(i_sense_value));
    always @(posedge i_core_clk) rd_d <= i_reg_rd;
    // Results settle by the falling edge
    always @(negedge i_core_clk) begin
        if (rd_d) begin
            exp_rd = notes.pop_front();
            `CHK("rdata", exp_rd, o_reg_rdata)
        end
        if (o_aging_apply === 1'b1) begin
            applies++;
            `CHK("trim", exp_trim, o_aging_trim)
        end
        if (o_sense_start === 1'b1) starts++;
    end
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Read when w is low, d then holds the expected byte
    task automatic rw(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_wr <= w;
        i_reg_rd <= !w;
        i_reg_wdata <= d;
        if (!w) notes.push_back(d);
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
    endtask
    task automatic rd_temp();
        rw(TEMP_INTEGER_ADDR, 1'b0, tval[9:2]);
        rw(TEMP_FRACTION_ADDR, 1'b0, {tval[1:0], 6'h00});
    endtask
    task automatic manual_conversion_request_wait();
        int n;
        repeat (3) @(posedge i_core_clk);
        for (n = 0; n < 100 && o_busy !== 1'b0; n++) @(negedge i_core_clk);
        if (o_busy !== 1'b0) begin
            miscompares++;
            give_verdict();
        end
        @(posedge i_core_clk);
    endtask
    task automatic wait_start(input int lim);
        int n;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (o_sense_start !== 1'b1 && n < lim);
        `CHK("start", 1'b1, o_sense_start)
        if (o_sense_start !== 1'b1) give_verdict();
        manual_conversion_request_wait();
    endtask
    task automatic manual();
        @(posedge i_core_clk);
        i_manual_conversion_request <= 1'b1;
        @(posedge i_core_clk);
        i_manual_conversion_request <= 1'b0;
    endtask
    initial begin
        void'($urandom(11));
        tval = 10'h065;
        repeat (3) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        rw(TEMP_INTEGER_ADDR, 1'b0, 8'h00);
        manual_conversion_request_wait();
        rd_temp();
        rw(TEMP_INTEGER_ADDR, 1'b1, 8'hA5);
        rw(TEMP_FRACTION_ADDR, 1'b1, 8'hFF);
        rd_temp();
        rw(8'h13, 1'b0, READ_UNMAPPED);
        for (int i = 0; i < 4; i++) begin
            exp_trim = 8'($urandom);
            tval = 10'($urandom);
            dly = 4'($urandom);
            rw(AGING_TRIM_ADDR, 1'b1, exp_trim);
            rw(AGING_TRIM_ADDR, 1'b0, exp_trim);
            manual();
            manual_conversion_request_wait();
            rd_temp();
        end
        `CHK("applies", 5, applies)
        dly = 4'hF;
        s0 = starts;
        manual();
        manual();
        manual_conversion_request_wait();
        manual_conversion_request_wait();
        `CHK("starts", s0 + 2, starts)
        s0 = applies;
        wait_start(210);
        `CHK("applies", s0, applies)
        tval = ~tval;
        wait_start(210);
        rd_temp();
        `CHK("applies", s0 + 1, applies)
        @(posedge i_core_clk);
        i_on_backup <= 1'b1;
        // Let the backup pin through its synchroniser first
        repeat (4) @(posedge i_core_clk);
        rw(AGING_TRIM_ADDR, 1'b0, exp_trim);
        wait_start(10);
        // Second power reset once the backup access conversion has ended
        i_on_backup <= 1'b0;
        i_reset_n <= 1'b0;
        exp_trim = AGING_TRIM_RESET;
        repeat (3) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        rw(TEMP_INTEGER_ADDR, 1'b0, 8'h00);
        rw(TEMP_FRACTION_ADDR, 1'b0, 8'h00);
        manual_conversion_request_wait();
        rd_temp();
        @(negedge i_core_clk);
        `CHK("scl", 2'b11, {o_scl_out, o_scl_oe})
        give_verdict();
    end
endmodule // temp_aging_register_block_tb
